// File: inc/cra_pkg.sv
// constants and types for the cpu register set and operand address generator
package cra_pkg;
	// ************************************************************
	// flags register layout
	// ************************************************************
	localparam logic [7:0] CRA_FLAGS_ADDR = 8'hf7;
	localparam int CRA_BIT_BANK = 4;
	localparam int CRA_BIT_SUPER = 3;
	localparam int CRA_BIT_CARRY = 2;
	localparam int CRA_BIT_ZERO = 1;
	localparam int CRA_BIT_GIE = 0;
	localparam logic [7:0] CRA_FLAGS_RESET = 8'h02;
	localparam logic [7:0] CRA_FLAGS_MASK = 8'h1f;
	localparam logic [7:0] CRA_FLAGS_WMASK = 8'h17;
	localparam logic [7:0] CRA_REG_RESET = 8'h00;
	localparam int CRA_BANK_DEPTH = 256;
	// ************************************************************
	// instruction classification
	// ************************************************************
	typedef enum logic [2:0] {
		CRA_AM_IMM, CRA_AM_SRC_DIR, CRA_AM_SRC_IDX,
		CRA_AM_DST_DIR, CRA_AM_DST_IDX, CRA_AM_NONE
	} cra_mode_t;
	typedef enum logic [1:0] {
		CRA_TGT_A, CRA_TGT_X, CRA_TGT_F, CRA_TGT_SP
	} cra_tgt_t;
	typedef enum logic [2:0] {
		CRA_OP_MOV, CRA_OP_ADD, CRA_OP_SUB, CRA_OP_AND,
		CRA_OP_OR, CRA_OP_XOR, CRA_OP_ADC
	} cra_alu_t;
	// one decoded instruction handed in by the sequencer
	typedef struct packed {
		cra_mode_t mode;
		cra_tgt_t tgt;
		cra_alu_t alu;
		logic reg_space;
		logic [7:0] operand;
	} cra_instr_t;
	// one memory access request
	typedef struct packed {
		logic rd;
		logic wr;
		logic reg_space;
		logic bank;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cra_access_t;
endpackage

// File: verilog/cra_alu.sv
// eight bit alu for logical and arithmetic operations
`timescale 1ns/10ps
module cra_alu (
	// operation
	input wire cra_pkg::cra_alu_t op,
	input wire logic carry_in,
	// operands
	input wire logic [7:0] left,
	input wire logic [7:0] right,
	// result
	output logic [7:0] result,
	output logic carry,
	output logic zero
);
	import cra_pkg::*;
	logic [8:0] sum;
	// combinational operation select
	always_comb begin
		sum = 9'h000;
		case (op)
			CRA_OP_MOV: sum = {1'b0, right};
			CRA_OP_ADD: sum = {1'b0, left} + {1'b0, right};
			CRA_OP_ADC: sum = {1'b0, left} + {1'b0, right} + {8'h00, carry_in};
			CRA_OP_SUB: sum = {1'b0, left} - {1'b0, right};
			CRA_OP_AND: sum = {1'b0, left & right};
			CRA_OP_OR: sum = {1'b0, left | right};
			CRA_OP_XOR: sum = {1'b0, left ^ right};
			default: sum = {1'b0, right};
		endcase
	end
	assign result = sum[7:0];
	assign carry = sum[8];
	assign zero = (sum[7:0] == 8'h00);
endmodule

// File: verilog/cra_regspace.sv
// two banks of 256 register-space locations with registered read data
`timescale 1ns/10ps
module cra_regspace (
	// clock, no reset
	input wire logic clk,
	// access port
	input wire logic wr,
	input wire logic bank,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	import cra_pkg::*;
	logic [7:0] mem [0:2*CRA_BANK_DEPTH-1];
	wire [8:0] index = {bank, addr};
	// write and registered read
	always_ff @(posedge clk) begin
		if (wr) begin
			mem[index] <= wdata;
		end
		rdata <= mem[index];
	end
endmodule

// File: verilog/cra_core.sv
// cpu register set with operand address generation
`timescale 1ns/10ps
module cra_core (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// instruction from the sequencer
	input wire logic issue,
	input wire cra_pkg::cra_instr_t instr,
	input wire logic supervisor,
	// program counter load
	input wire logic pc_load,
	input wire logic [15:0] pc_value,
	input wire logic pc_step,
	// stack pointer load
	input wire logic sp_load,
	input wire logic [7:0] sp_value,
	// ram space port
	output cra_pkg::cra_access_t ram_req,
	input wire logic [7:0] ram_rdata,
	// status
	output logic busy,
	output logic [7:0] flags,
	output logic [7:0] acc,
	output logic [7:0] index,
	output logic [7:0] stack_ptr,
	output logic [7:0] program_counter_high,
	output logic [7:0] program_counter_low,
	output logic global_interrupt_enable
);
	import cra_pkg::*;
	// ************************************************************
	// state and registers
	// ************************************************************
	typedef enum logic [1:0] {CRA_ST_IDLE, CRA_ST_READ, CRA_ST_EXEC} cra_st_t;
	cra_st_t state;
	cra_st_t next_state;
	cra_instr_t cur;
	logic [4:0] flag_bits; // bank, super, carry, zero, gie
	logic register_bank_select;
	logic [7:0] rd_data;
	// ************************************************************
	// operand address generation
	// ************************************************************
	wire is_idx = (cur.mode == CRA_AM_SRC_IDX) || (cur.mode == CRA_AM_DST_IDX);
	wire [7:0] eff_addr = is_idx ? 8'(cur.operand + index)
		: cur.operand;
	wire is_dst = (cur.mode == CRA_AM_DST_DIR) || (cur.mode == CRA_AM_DST_IDX);
	wire is_src_mem = (cur.mode == CRA_AM_SRC_DIR) ||
		(cur.mode == CRA_AM_SRC_IDX);
	wire needs_read = is_src_mem || (is_dst && cur.alu != CRA_OP_MOV);
	wire flags_hit = cur.reg_space && (eff_addr == CRA_FLAGS_ADDR);
	wire [7:0] flags_view = {3'h0, flag_bits} & CRA_FLAGS_MASK;
	assign register_bank_select = flag_bits[CRA_BIT_BANK];
	// ************************************************************
	// data path
	// ************************************************************
	logic [7:0] reg_rdata;
	// register space answers one cycle late, so its data is taken live in exec
	wire [7:0] mem_data = (cur.reg_space && !flags_hit) ? reg_rdata
		: rd_data;
	// second operand follows the mode: source register, immediate operand or memory location
	wire [7:0] tgt_val = (cur.tgt == CRA_TGT_X) ? index
		: (cur.tgt == CRA_TGT_F) ? flags_view
		: (cur.tgt == CRA_TGT_SP) ? stack_ptr : acc;
	wire dst_src_x = (cur.mode == CRA_AM_DST_DIR) && (cur.tgt == CRA_TGT_X);
	wire [7:0] src_reg = dst_src_x ? index : acc;
	wire [7:0] alu_left = is_dst ? mem_data : tgt_val;
	wire [7:0] alu_right = is_dst ? src_reg
		: (cur.mode == CRA_AM_IMM) ? cur.operand : mem_data;
	logic [7:0] alu_res;
	logic alu_carry;
	logic alu_zero;
	cra_alu u_alu (
		.op(cur.alu),
		.carry_in(flag_bits[CRA_BIT_CARRY]),
		.left(alu_left),
		.right(alu_right),
		.result(alu_res),
		.carry(alu_carry),
		.zero(alu_zero)
	);
	wire exec = (state == CRA_ST_EXEC);
	wire is_logic_arith = (cur.alu != CRA_OP_MOV);
	wire wr_flags = exec && (cur.mode == CRA_AM_IMM) &&
		(cur.tgt == CRA_TGT_F);
	wire mem_wr = exec && is_dst;
	// ************************************************************
	// memory ports
	// ************************************************************
	wire rd_phase = (state == CRA_ST_READ);
	wire reg_wr = mem_wr && cur.reg_space && !flags_hit;
	cra_regspace u_regs (
		.clk(clk),
		.wr(reg_wr),
		.bank(register_bank_select),
		.addr(eff_addr),
		.wdata(alu_res),
		.rdata(reg_rdata)
	);
	assign ram_req = '{rd: rd_phase && !cur.reg_space,
		wr: mem_wr && !cur.reg_space,
		reg_space: 1'b0,
		bank: 1'b0,
		addr: eff_addr,
		wdata: alu_res};
	// ************************************************************
	// sequencing
	// ************************************************************
	always_comb begin
		next_state = state;
		case (state)
			CRA_ST_IDLE: if (issue && instr.mode != CRA_AM_NONE) begin
				next_state = CRA_ST_READ;
			end
			CRA_ST_READ: next_state = CRA_ST_EXEC;
			CRA_ST_EXEC: next_state = CRA_ST_IDLE;
			default: next_state = CRA_ST_IDLE;
		endcase
	end
	assign busy = (state != CRA_ST_IDLE);
	// state register and instruction latch
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= CRA_ST_IDLE;
			cur <= '0;
			rd_data <= CRA_REG_RESET;
		end else begin
			state <= next_state;
			if (state == CRA_ST_IDLE && issue) begin
				cur <= instr;
			end
			if (rd_phase) begin
				rd_data <= needs_read ? (flags_hit ? flags_view
					: ram_rdata) : CRA_REG_RESET;
			end
		end
	end
	// ************************************************************
	// cpu registers
	// ************************************************************
	wire [7:0] exec_data = cur.mode == CRA_AM_IMM ? alu_res : alu_res;
	always_ff @(posedge clk) begin
		if (rst) begin
			acc <= CRA_REG_RESET;
			index <= CRA_REG_RESET;
		end else if (exec && !is_dst) begin
			if (cur.tgt == CRA_TGT_A) begin
				acc <= exec_data;
			end
			if (cur.tgt == CRA_TGT_X) begin
				index <= exec_data;
			end
		end
	end
	// stack pointer: load from sequencer, or immediate mode target
	always_ff @(posedge clk) begin
		if (rst) begin
			stack_ptr <= CRA_REG_RESET;
		end else if (exec && cur.mode == CRA_AM_IMM &&
			cur.tgt == CRA_TGT_SP) begin
			stack_ptr <= alu_res;
		end else if (sp_load) begin
			stack_ptr <= sp_value;
		end
	end
	// program counter kept as two bytes
	always_ff @(posedge clk) begin
		if (rst) begin
			program_counter_high <= CRA_REG_RESET;
			program_counter_low <= CRA_REG_RESET;
		end else if (pc_load) begin
			program_counter_high <= pc_value[15:8];
			program_counter_low <= pc_value[7:0];
		end else if (pc_step) begin
			{program_counter_high, program_counter_low} <=
				16'({program_counter_high, program_counter_low} + 16'h0001);
		end
	end
	// flags: immediate write, else alu status after logical or arithmetic
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_bits <= CRA_FLAGS_RESET[4:0];
		end else begin
			flag_bits[CRA_BIT_SUPER] <= supervisor;
			if (wr_flags) begin
				flag_bits[CRA_BIT_BANK] <= alu_res[CRA_BIT_BANK];
				flag_bits[CRA_BIT_CARRY] <= alu_res[CRA_BIT_CARRY];
				flag_bits[CRA_BIT_ZERO] <= alu_res[CRA_BIT_ZERO];
				flag_bits[CRA_BIT_GIE] <= alu_res[CRA_BIT_GIE];
			end else if (exec && is_logic_arith) begin
				flag_bits[CRA_BIT_CARRY] <= alu_carry;
				flag_bits[CRA_BIT_ZERO] <= alu_zero;
			end
		end
	end
	assign flags = flags_view;
	assign global_interrupt_enable = flag_bits[CRA_BIT_GIE];
	// ************************************************************
	// checks
	// ************************************************************
	chk_flags_upper: assert property (@(posedge clk) disable iff (rst)
		flags[7:5] == 3'h0) else $error("flags upper bits not zero");
	chk_super_follow: assert property (@(posedge clk) disable iff (rst)
		$past(supervisor) == flags[CRA_BIT_SUPER] || $past(rst))
		else $error("super flag wrong");
	chk_dst_acc_hold: assert property (@(posedge clk) disable iff (rst)
		(exec && is_dst) |=> $stable(acc))
		else $error("acc changed on destination mode");
	chk_zero_update: assert property (@(posedge clk) disable iff (rst)
		(exec && is_logic_arith && !wr_flags) |=>
		flags[CRA_BIT_ZERO] == $past(alu_zero))
		else $error("zero flag wrong");
	chk_carry_update: assert property (@(posedge clk) disable iff (rst)
		(exec && is_logic_arith && !wr_flags) |=>
		flags[CRA_BIT_CARRY] == $past(alu_carry))
		else $error("carry flag wrong");
	chk_seq_len: assert property (@(posedge clk) disable iff (rst)
		(state == CRA_ST_READ) |=> exec ##1 !busy)
		else $error("sequence length wrong");
	chk_acc_capture: assert property (@(posedge clk) disable iff (rst)
		(exec && !is_dst && cur.tgt == CRA_TGT_A) |=> acc == $past(alu_res))
		else $error("acc not captured");
	chk_idx_addr: assert property (@(posedge clk) disable iff (rst)
		(busy && is_idx) |-> eff_addr == 8'(cur.operand + index))
		else $error("indexed address wrong");
	chk_ram_no_reg: assert property (@(posedge clk) disable iff (rst)
		reg_wr |-> !ram_req.wr) else $error("both spaces written");
endmodule

// File: verification/cra_ram_model.sv
// ram-space model answering the core's operand reads and writes
`timescale 1ns/10ps
module cra_ram_model (
	// clock
	input wire logic clk,
	// access from the core
	input wire cra_pkg::cra_access_t req,
	output logic [7:0] rdata
);
	import cra_pkg::*;
	logic [7:0] mem [0:255];
	logic [7:0] last;
	// preset contents with a pattern the bench also knows
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
		last = 8'h00;
	end
	// read is combinational; an idle bus shows the inverse of the last value
	assign rdata = req.rd ? mem[req.addr] : ~last;
	// writes land at the edge that ends the execute cycle
	always @(posedge clk) begin
		if (req.rd) begin
			last <= mem[req.addr];
		end
		if (req.wr) begin
			mem[req.addr] <= req.wdata;
		end
	end
endmodule

// File: verification/cra_core_tb.sv
// self-checking bench for the register set and operand addressing
`timescale 1ns/10ps
module cra_core_tb;
	import cra_pkg::*;
	logic clk, rst, issue, supervisor, pc_load, pc_step, sp_load, busy, gie;
	cra_instr_t instr;
	cra_access_t ram_req;
	logic [15:0] pc_value;
	logic [7:0] sp_value, ram_rdata, flags, acc, index, stack_ptr, pc_hi, pc_lo;
	logic [7:0] sh [0:255];
	logic [7:0] ea, ex, v, d;
	logic [8:0] s;
	int bad_count = 0;
	int tests_run = 0;
	int seed = 94;
	cra_core dut (.clk(clk), .rst(rst), .issue(issue), .instr(instr),
		.supervisor(supervisor), .pc_load(pc_load), .pc_value(pc_value),
		.pc_step(pc_step), .sp_load(sp_load), .sp_value(sp_value),
		.ram_req(ram_req), .ram_rdata(ram_rdata), .busy(busy), .flags(flags),
		.acc(acc), .index(index), .stack_ptr(stack_ptr),
		.program_counter_high(pc_hi), .program_counter_low(pc_lo),
		.global_interrupt_enable(gie));
	cra_ram_model rm (.clk(clk), .req(ram_req), .rdata(ram_rdata));
	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask
	// issue one instruction and wait for the core to go idle
	task automatic run(input cra_mode_t m, input cra_tgt_t t,
		input cra_alu_t a, input logic rs, input logic [7:0] opd);
		@(posedge clk);
		issue <= 1'b1;
		instr <= '{m, t, a, rs, opd};
		@(posedge clk);
		issue <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			#1;
			if (busy === 1'b0) break;
		end
		if (busy !== 1'b0) chk("busy", 16'h0, 16'(busy));
	endtask
	// expected alu result with carry in bit 8
	function automatic logic [8:0] alu(input cra_alu_t a, input logic [7:0] l,
		input logic [7:0] r, input logic c);
		case (a)
			CRA_OP_MOV: return {1'b0, r};
			CRA_OP_ADD: return {1'b0, l} + {1'b0, r};
			CRA_OP_SUB: return {1'b0, l} - {1'b0, r};
			CRA_OP_AND: return {1'b0, l & r};
			CRA_OP_OR: return {1'b0, l | r};
			CRA_OP_XOR: return {1'b0, l ^ r};
			default: return {1'b0, l} + {1'b0, r} + 9'(c);
		endcase
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#2000000;
		bad_count++;
		tally_and_finish;
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		issue = 1'b0;
		instr = '0;
		supervisor = 1'b0;
		pc_load = 1'b0;
		pc_step = 1'b0;
		pc_value = 16'h0000;
		sp_load = 1'b0;
		sp_value = 8'h00;
		for (int i = 0; i < 256; i++) sh[i] = 8'(i) ^ 8'h5a;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("flags reset", 16'h0002, flags);
		chk("gie reset", 16'h0, gie);
		chk("a x reset", 16'h0, {acc, index});
		chk("sp reset", 16'h0, stack_ptr);
		chk("pc reset", 16'h0, {pc_hi, pc_lo});
		// every alu code except add with carry with an immediate into the accumulator
		ea = 8'h00;
		for (int k = 0; k < 6; k++) begin
			v = $random(seed);
			s = alu(cra_alu_t'(k), ea, v, 1'b0);
			run(CRA_AM_IMM, CRA_TGT_A, cra_alu_t'(k), 1'b0, v);
			ea = s[7:0];
			chk("acc imm", ea, acc);
		end
		// carry and zero corner, then add with carry
		run(CRA_AM_IMM, CRA_TGT_A, CRA_OP_MOV, 1'b0, 8'hf0);
		run(CRA_AM_IMM, CRA_TGT_A, CRA_OP_ADD, 1'b0, 8'h10);
		chk("carry zero", 16'h3, flags[2:1]);
		run(CRA_AM_IMM, CRA_TGT_A, CRA_OP_ADC, 1'b0, 8'h05);
		chk("acc adc", 16'h06, acc);
		chk("carry zero clr", 16'h0, flags[2:1]);
		// flags only through or and and immediate
		run(CRA_AM_IMM, CRA_TGT_F, CRA_OP_OR, 1'b0, 8'hf9);
		chk("flags or", 16'h0011, flags);
		chk("gie set", 16'h1, gie);
		run(CRA_AM_IMM, CRA_TGT_F, CRA_OP_AND, 1'b0, 8'hfe);
		chk("flags and", 16'h0010, flags);
		@(posedge clk);
		supervisor <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("super", 16'h1, flags[3]);
		run(CRA_AM_SRC_DIR, CRA_TGT_A, CRA_OP_MOV, 1'b1, 8'hf7);
		chk("flags read", 16'h0018, acc);
		run(CRA_AM_DST_DIR, CRA_TGT_A, CRA_OP_MOV, 1'b1, 8'h40);
		chk("reg write ram", sh[8'h40], rm.mem[8'h40]);
		run(CRA_AM_SRC_DIR, CRA_TGT_X, CRA_OP_MOV, 1'b1, 8'h40);
		chk("reg read back", 16'h18, index);
		run(CRA_AM_IMM, CRA_TGT_X, CRA_OP_MOV, 1'b0, 8'h08);
		chk("index imm", 16'h08, index);
		// random ram traffic through every addressing mode
		for (int k = 0; k < 12; k++) begin
			ex = $random(seed);
			ea = $random(seed);
			d = $random(seed);
			run(CRA_AM_IMM, CRA_TGT_X, CRA_OP_MOV, 1'b0, ex);
			run(CRA_AM_IMM, CRA_TGT_A, CRA_OP_MOV, 1'b0, ea);
			v = d + ex;
			run(CRA_AM_DST_IDX, CRA_TGT_A, CRA_OP_ADD, 1'b0, d);
			sh[v] = sh[v] + ea;
			chk("ram idx", sh[v], rm.mem[v]);
			chk("acc kept", ea, acc);
			run(CRA_AM_DST_DIR, CRA_TGT_X, CRA_OP_MOV, 1'b0, d);
			sh[d] = ex;
			chk("ram dir", sh[d], rm.mem[d]);
			run(CRA_AM_SRC_IDX, CRA_TGT_A, CRA_OP_ADD, 1'b0, d);
			ea = ea + sh[v];
			chk("acc idx", ea, acc);
			run(CRA_AM_SRC_DIR, CRA_TGT_X, CRA_OP_XOR, 1'b0, v);
			chk("index dir", ex ^ sh[v], index);
		end
		// program counter load and step, stack pointer load
		@(posedge clk);
		pc_load <= 1'b1;
		pc_value <= 16'($random(seed));
		@(posedge clk);
		pc_load <= 1'b0;
		pc_step <= 1'b1;
		@(posedge clk);
		pc_step <= 1'b0;
		sp_load <= 1'b1;
		sp_value <= 8'($random(seed));
		@(posedge clk);
		sp_load <= 1'b0;
		#1;
		chk("pc", pc_value + 16'h1, {pc_hi, pc_lo});
		chk("sp", sp_value, stack_ptr);
		tally_and_finish;
	end
endmodule
